// file: design/pllcfg_regs.sv
// Configuration register bank for loops two to four and the output driver
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Loop two pump current, four bits in bits 3:0, reset 0010.
// - Loop two and three oscillator range bytes, reset 0x0C and 0x05.
// - Loop three bit 4 halves the output when set, reset 0.
// - Loop three bit 3 forces loop off; else crosspoint mode decides.
// - Loop three pump current, bits 3:0, reset 0011.
// - Loop four bits 7:4 divide output by two to that power, reset 0010.
// - Loop four bit 3 shuts the loop down when set, reset 0.
// - Loop four bit 1 picks 125 MHz over 100 MHz, reset 0.
// - Loop four bit 0 picks external reference over internal 27 MHz.
// - Loop four pump current, bits 3:0, reset 1000.
// - Loop four reference divider, seven bits 6:0, reset 1001011.
// - Loop four feedback divider ten bits: high two, low eight bytes.
// - Loop four oscillator center code, full byte, reset 0x16.
// - Driver bit 7 enables pre-emphasis, reset 0.
// - Driver bits 6:4 select output swing, reset 100.
// - Driver bits 3:0 select common-mode level, reset 1001.
module pllcfg_regs (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port from the serial host decoder
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_ack,
  // Crosspoint mode request for loop three
  input wire logic crosspoint_loop3_on,
  // Loop two
  output logic [3:0] loop2_pump_current,
  output logic [7:0] loop2_osc_range,
  // Loop three
  output logic loop3_half_rate,
  output logic loop3_enable,
  output logic [3:0] loop3_pump_current,
  output logic [7:0] loop3_osc_range,
  // Loop four
  output logic [3:0] loop4_power_of_two_divider,
  output logic [15:0] loop4_divide_ratio,
  output logic loop4_shutdown,
  output logic loop4_enable,
  output logic ref_high_rate_select,
  output logic loop4_ref_source,
  output logic [3:0] loop4_pump_current,
  output logic [6:0] loop4_reference_divider,
  output logic [1:0] loop4_feedback_high_bits,
  output logic [7:0] loop4_feedback_low_bits,
  output logic [9:0] loop4_feedback_divider,
  output logic [7:0] loop4_osc_center,
  // Differential output driver
  output logic output_preemphasis,
  output logic [2:0] output_swing_code,
  output logic [3:0] output_common_mode_code
);

  pllcfg_pkg::pllcfg_state_s st_r;
  pllcfg_pkg::pllcfg_state_s st_nxt;

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a >= pllcfg_pkg::OFS_L2_ICP) && (a <= pllcfg_pkg::OFS_DRV);
  endfunction

  // Builds the byte a read returns; reserved positions stay zero
  function automatic logic [7:0] reg_image(
    input logic [7:0] a,
    input pllcfg_pkg::pllcfg_state_s s
  );
    logic [7:0] v;
    v = 8'h00;
    case (a)
      pllcfg_pkg::OFS_L2_ICP: v[3:0] = s.l2_icp;
      pllcfg_pkg::OFS_L2_RANGE: v = s.l2_range;
      pllcfg_pkg::OFS_L3_MAIN: begin
        v[pllcfg_pkg::L3_HALF_BIT] = s.l3_half;
        v[pllcfg_pkg::L3_OFF_BIT] = s.l3_off;
      end
      pllcfg_pkg::OFS_L3_ICP: v[3:0] = s.l3_icp;
      pllcfg_pkg::OFS_L3_RANGE: v = s.l3_range;
      pllcfg_pkg::OFS_L4_MAIN: begin
        v[7:4] = s.l4_div;
        v[pllcfg_pkg::L4_OFF_BIT] = s.l4_off;
        v[pllcfg_pkg::L4_HI_RATE_BIT] = s.l4_hi;
        v[pllcfg_pkg::L4_EXT_BIT] = s.l4_ext;
      end
      pllcfg_pkg::OFS_L4_ICP: v[3:0] = s.l4_icp;
      pllcfg_pkg::OFS_L4_RDIV: v[6:0] = s.l4_rdiv;
      pllcfg_pkg::OFS_L4_NHI: v[1:0] = s.l4_nhi;
      pllcfg_pkg::OFS_L4_NLO: v = s.l4_nlo;
      pllcfg_pkg::OFS_L4_CENTER: v = s.l4_center;
      pllcfg_pkg::OFS_DRV: begin
        v[pllcfg_pkg::DRV_BOOST_BIT] = s.boost;
        v[6:4] = s.swing;
        v[3:0] = s.cm;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      st_nxt.ack = reg_rd || reg_wr;
      // A read in the same cycle as a write sees the old contents
      if (reg_rd) begin
        st_nxt.rdata = reg_image(reg_addr, st_r);
      end
      if (reg_wr) begin
        case (reg_addr)
          pllcfg_pkg::OFS_L2_ICP: begin
            st_nxt.l2_icp = reg_wdata[3:0];
          end
          pllcfg_pkg::OFS_L2_RANGE: begin
            st_nxt.l2_range = reg_wdata;
          end
          pllcfg_pkg::OFS_L3_MAIN: begin
            st_nxt.l3_half = reg_wdata[pllcfg_pkg::L3_HALF_BIT];
            st_nxt.l3_off = reg_wdata[pllcfg_pkg::L3_OFF_BIT];
          end
          pllcfg_pkg::OFS_L3_ICP: begin
            st_nxt.l3_icp = reg_wdata[3:0];
          end
          pllcfg_pkg::OFS_L3_RANGE: begin
            st_nxt.l3_range = reg_wdata;
          end
          pllcfg_pkg::OFS_L4_MAIN: begin
            st_nxt.l4_div = reg_wdata[7:4];
            st_nxt.l4_off = reg_wdata[pllcfg_pkg::L4_OFF_BIT];
            st_nxt.l4_hi = reg_wdata[pllcfg_pkg::L4_HI_RATE_BIT];
            st_nxt.l4_ext = reg_wdata[pllcfg_pkg::L4_EXT_BIT];
          end
          pllcfg_pkg::OFS_L4_ICP: begin
            st_nxt.l4_icp = reg_wdata[3:0];
          end
          pllcfg_pkg::OFS_L4_RDIV: begin
            st_nxt.l4_rdiv = reg_wdata[6:0];
          end
          pllcfg_pkg::OFS_L4_NHI: begin
            st_nxt.l4_nhi = reg_wdata[1:0];
          end
          pllcfg_pkg::OFS_L4_NLO: begin
            st_nxt.l4_nlo = reg_wdata;
          end
          pllcfg_pkg::OFS_L4_CENTER: begin
            st_nxt.l4_center = reg_wdata;
          end
          pllcfg_pkg::OFS_DRV: begin
            st_nxt.boost = reg_wdata[pllcfg_pkg::DRV_BOOST_BIT];
            st_nxt.swing = reg_wdata[6:4];
            st_nxt.cm = reg_wdata[3:0];
          end
          default: begin
            st_nxt.ack = st_nxt.ack;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= pllcfg_pkg::RST_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The two higher feedback bits and the low byte are held apart so a
  // host can stage them; the loop sees the pair together one cycle on
  pllcfg_loop_ctl #(
    .DIV_CODE_W(4),
    .RATIO_W(16)
  ) u_loop_ctl (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .crosspoint_loop3_on(crosspoint_loop3_on),
    .l3_off(st_r.l3_off),
    .l4_off(st_r.l4_off),
    .l4_div(st_r.l4_div),
    .l4_nhi(st_r.l4_nhi),
    .l4_nlo(st_r.l4_nlo),
    .loop3_enable(loop3_enable),
    .loop4_enable(loop4_enable),
    .loop4_feedback_divider(loop4_feedback_divider),
    .loop4_divide_ratio(loop4_divide_ratio)
  );

  assign reg_rdata = st_r.rdata;
  assign reg_ack = st_r.ack;
  assign loop2_pump_current = st_r.l2_icp;
  assign loop2_osc_range = st_r.l2_range;
  assign loop3_half_rate = st_r.l3_half;
  assign loop3_pump_current = st_r.l3_icp;
  assign loop3_osc_range = st_r.l3_range;
  assign loop4_power_of_two_divider = st_r.l4_div;
  assign loop4_shutdown = st_r.l4_off;
  assign ref_high_rate_select = st_r.l4_hi;
  assign loop4_ref_source = st_r.l4_ext;
  assign loop4_pump_current = st_r.l4_icp;
  assign loop4_reference_divider = st_r.l4_rdiv;
  assign loop4_feedback_high_bits = st_r.l4_nhi;
  assign loop4_feedback_low_bits = st_r.l4_nlo;
  assign loop4_osc_center = st_r.l4_center;
  assign output_preemphasis = st_r.boost;
  assign output_swing_code = st_r.swing;
  assign output_common_mode_code = st_r.cm;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  function automatic logic wr_at(input logic [7:0] ofs);
    return ce && reg_wr && (reg_addr == ofs);
  endfunction

  sequence s_rd_same(logic [7:0] ofs);
    ce && reg_rd && !reg_wr && (reg_addr == ofs);
  endsequence

  // Write, then read the same place in the next cycle; only mask bits stick
  property p_readback(logic [7:0] ofs, logic [7:0] mask);
    wr_at(ofs) ##1 s_rd_same(ofs)
      |=> reg_rdata == ($past(reg_wdata, 2) & mask) && reg_ack;
  endproperty

  a_l2_icp_rb: assert property (
    p_readback(pllcfg_pkg::OFS_L2_ICP, 8'h0F))
    else $error("loop two pump current readback wrong");

  a_osc_range_rb: assert property (
    p_readback(pllcfg_pkg::OFS_L3_RANGE, 8'hFF))
    else $error("loop three range readback wrong");

  a_l2_range_wr: assert property (
    wr_at(pllcfg_pkg::OFS_L2_RANGE)
      |=> loop2_osc_range == $past(reg_wdata))
    else $error("loop two range not written");

  a_l3_half_wr: assert property (
    wr_at(pllcfg_pkg::OFS_L3_MAIN)
      |=> loop3_half_rate == $past(reg_wdata[4]))
    else $error("loop three half rate not written");

  a_l3_enable: assert property (
    ce |=> loop3_enable ==
      ($past(crosspoint_loop3_on) && !$past(st_r.l3_off)))
    else $error("loop three enable wrong");

  a_l3_icp_rb: assert property (
    p_readback(pllcfg_pkg::OFS_L3_ICP, 8'h0F))
    else $error("loop three pump current readback wrong");

  a_l4_ratio: assert property (
    wr_at(pllcfg_pkg::OFS_L4_MAIN) && !reg_wdata[7] ##1 ce
      |=> loop4_divide_ratio == (16'h0001 << $past(reg_wdata[6:4], 2)))
    else $error("loop four divide ratio wrong");

  a_l4_shutdown: assert property (
    wr_at(pllcfg_pkg::OFS_L4_MAIN) && reg_wdata[3] ##1 ce
      |=> !loop4_enable && $past(loop4_shutdown))
    else $error("loop four not shut down");

  a_l4_ref_bits: assert property (
    wr_at(pllcfg_pkg::OFS_L4_MAIN)
      |=> {ref_high_rate_select, loop4_ref_source} ==
        $past(reg_wdata[1:0]))
    else $error("loop four reference bits wrong");

  a_l4_main_rsvd: assert property (
    p_readback(pllcfg_pkg::OFS_L4_MAIN, 8'hFB))
    else $error("loop four main readback wrong");

  a_l4_icp_rb: assert property (
    p_readback(pllcfg_pkg::OFS_L4_ICP, 8'h0F))
    else $error("loop four pump current readback wrong");

  a_l4_rdiv_rb: assert property (
    p_readback(pllcfg_pkg::OFS_L4_RDIV, 8'h7F))
    else $error("loop four reference divider readback wrong");

  a_l4_ndiv_join: assert property (
    ce |=> loop4_feedback_divider ==
      {$past(st_r.l4_nhi), $past(st_r.l4_nlo)})
    else $error("loop four feedback divider not joined");

  a_l4_center_rb: assert property (
    p_readback(pllcfg_pkg::OFS_L4_CENTER, 8'hFF))
    else $error("loop four center readback wrong");

  a_drv_rb: assert property (
    p_readback(pllcfg_pkg::OFS_DRV, 8'hFF))
    else $error("driver control readback wrong");

  a_drv_fields: assert property (
    wr_at(pllcfg_pkg::OFS_DRV) |=> {output_preemphasis,
      output_swing_code, output_common_mode_code} == $past(reg_wdata))
    else $error("driver fields not written");

  a_l3_main_rsvd: assert property (
    ce && reg_rd && reg_addr == pllcfg_pkg::OFS_L3_MAIN
      |=> reg_rdata[7:5] == 3'h0 && reg_rdata[2:0] == 3'h0)
    else $error("loop three reserved bits not zero");

  a_unmapped_zero: assert property (
    ce && reg_rd && !addr_mapped(reg_addr) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_l2_icp_wr: assert property (
    wr_at(pllcfg_pkg::OFS_L2_ICP)
      |=> loop2_pump_current == $past(reg_wdata[3:0]))
    else $error("loop two pump current not written");

  a_l2_range_rb: assert property (
    p_readback(pllcfg_pkg::OFS_L2_RANGE, 8'hFF))
    else $error("loop two range readback wrong");

  a_l3_main_rb: assert property (
    p_readback(pllcfg_pkg::OFS_L3_MAIN, 8'h18))
    else $error("loop three main readback wrong");

  a_l4_off_wr: assert property (
    wr_at(pllcfg_pkg::OFS_L4_MAIN)
      |=> loop4_shutdown == $past(reg_wdata[3]))
    else $error("loop four shutdown bit not written");

  a_l4_nhi_rb: assert property (
    p_readback(pllcfg_pkg::OFS_L4_NHI, 8'h03))
    else $error("loop four feedback high readback wrong");

  a_l4_nlo_rb: assert property (
    p_readback(pllcfg_pkg::OFS_L4_NLO, 8'hFF))
    else $error("loop four feedback low readback wrong");

  a_unmapped_wr: assert property (
    ce && reg_wr && !reg_rd && !addr_mapped(reg_addr)
      |=> reg_ack && $stable(loop2_pump_current) &&
        $stable(output_common_mode_code) && $stable(loop4_osc_center))
    else $error("unmapped write changed a field");

  a_freeze_hold: assert property (
    !ce |=> $stable(output_common_mode_code) && $stable(reg_rdata))
    else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// file: shared/pllcfg_pkg.sv
// Offsets, field positions, reset values and state for the loop config bank
package pllcfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_L2_ICP = 8'h2F;
  localparam logic [7:0] OFS_L2_RANGE = 8'h30;
  localparam logic [7:0] OFS_L3_MAIN = 8'h31;
  localparam logic [7:0] OFS_L3_ICP = 8'h32;
  localparam logic [7:0] OFS_L3_RANGE = 8'h33;
  localparam logic [7:0] OFS_L4_MAIN = 8'h34;
  localparam logic [7:0] OFS_L4_ICP = 8'h35;
  localparam logic [7:0] OFS_L4_RDIV = 8'h36;
  localparam logic [7:0] OFS_L4_NHI = 8'h37;
  localparam logic [7:0] OFS_L4_NLO = 8'h38;
  localparam logic [7:0] OFS_L4_CENTER = 8'h39;
  localparam logic [7:0] OFS_DRV = 8'h3A;

  // Field positions
  localparam int ICP_LSB = 0;
  localparam int L3_HALF_BIT = 4;
  localparam int L3_OFF_BIT = 3;
  localparam int L4_DIV_LSB = 4;
  localparam int L4_OFF_BIT = 3;
  localparam int L4_HI_RATE_BIT = 1;
  localparam int L4_EXT_BIT = 0;
  localparam int RDIV_LSB = 0;
  localparam int NHI_LSB = 0;
  localparam int DRV_BOOST_BIT = 7;
  localparam int DRV_SWING_LSB = 4;
  localparam int DRV_CM_LSB = 0;

  // Reset values
  localparam logic [3:0] RST_L2_ICP = 4'h2;
  localparam logic [7:0] RST_L2_RANGE = 8'h0C;
  localparam logic RST_L3_HALF = 1'h0;
  localparam logic RST_L3_OFF = 1'h0;
  localparam logic [3:0] RST_L3_ICP = 4'h3;
  localparam logic [7:0] RST_L3_RANGE = 8'h05;
  localparam logic [3:0] RST_L4_DIV = 4'h2;
  localparam logic RST_L4_OFF = 1'h0;
  localparam logic RST_L4_HI = 1'h0;
  localparam logic RST_L4_EXT = 1'h0;
  localparam logic [3:0] RST_L4_ICP = 4'h8;
  localparam logic [6:0] RST_L4_RDIV = 7'h4B;
  localparam logic [1:0] RST_L4_NHI = 2'h2;
  localparam logic [7:0] RST_L4_NLO = 8'h00;
  localparam logic [7:0] RST_L4_CENTER = 8'h16;
  localparam logic RST_BOOST = 1'h0;
  localparam logic [2:0] RST_SWING = 3'h4;
  localparam logic [3:0] RST_CM = 4'h9;

  typedef struct packed {
    logic [3:0] l2_icp;
    logic [7:0] l2_range;
    logic l3_half;
    logic l3_off;
    logic [3:0] l3_icp;
    logic [7:0] l3_range;
    logic [3:0] l4_div;
    logic l4_off;
    logic l4_hi;
    logic l4_ext;
    logic [3:0] l4_icp;
    logic [6:0] l4_rdiv;
    logic [1:0] l4_nhi;
    logic [7:0] l4_nlo;
    logic [7:0] l4_center;
    logic boost;
    logic [2:0] swing;
    logic [3:0] cm;
    logic [7:0] rdata;
    logic ack;
  } pllcfg_state_s;

  localparam pllcfg_state_s RST_STATE = '{
    l2_icp: RST_L2_ICP, l2_range: RST_L2_RANGE,
    l3_half: RST_L3_HALF, l3_off: RST_L3_OFF,
    l3_icp: RST_L3_ICP, l3_range: RST_L3_RANGE,
    l4_div: RST_L4_DIV, l4_off: RST_L4_OFF,
    l4_hi: RST_L4_HI, l4_ext: RST_L4_EXT,
    l4_icp: RST_L4_ICP, l4_rdiv: RST_L4_RDIV,
    l4_nhi: RST_L4_NHI, l4_nlo: RST_L4_NLO,
    l4_center: RST_L4_CENTER, boost: RST_BOOST,
    swing: RST_SWING, cm: RST_CM,
    rdata: 8'h00, ack: 1'h0
  };

endpackage

// file: design/pllcfg_loop_ctl.sv
// Registered loop enable and divider decode for the third and fourth loops
`timescale 1ns/100ps
`default_nettype none

module pllcfg_loop_ctl #(
  parameter int DIV_CODE_W = 4,
  parameter int RATIO_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Settings
  input wire logic crosspoint_loop3_on,
  input wire logic l3_off,
  input wire logic l4_off,
  input wire logic [DIV_CODE_W-1:0] l4_div,
  input wire logic [1:0] l4_nhi,
  input wire logic [7:0] l4_nlo,
  // Derived controls
  output logic loop3_enable,
  output logic loop4_enable,
  output logic [9:0] loop4_feedback_divider,
  output logic [RATIO_W-1:0] loop4_divide_ratio
);

  if (RATIO_W != (1 << DIV_CODE_W)) begin : g_chk
    $error("pllcfg_loop_ctl: RATIO_W must be 2**DIV_CODE_W");
  end

  typedef struct packed {
    logic l3_en;
    logic l4_en;
    logic [9:0] ndiv;
    logic [RATIO_W-1:0] ratio;
  } pllcfg_ctl_s;

  pllcfg_ctl_s st_r;
  pllcfg_ctl_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      // Forced off wins; otherwise crosspoint mode decides
      st_nxt.l3_en = crosspoint_loop3_on && !l3_off;
      st_nxt.l4_en = !l4_off;
      st_nxt.ndiv = {l4_nhi, l4_nlo};
      st_nxt.ratio = {{(RATIO_W-1){1'b0}}, 1'b1} << l4_div;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign loop3_enable = st_r.l3_en;
  assign loop4_enable = st_r.l4_en;
  assign loop4_feedback_divider = st_r.ndiv;
  assign loop4_divide_ratio = st_r.ratio;

endmodule

`default_nettype wire

// file: verification/test_pllcfg_regs.sv
// Self-checking bench for the loop configuration register bank
`timescale 1ns/100ps
`default_nettype none

module test_pllcfg_regs;
  logic mclk, rst_n, ce, reg_wr, reg_rd, crosspoint_loop3_on;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_ack, loop3_half_rate, loop3_enable, loop4_shutdown, loop4_enable;
  logic ref_high_rate_select, loop4_ref_source, output_preemphasis;
  logic [3:0] loop2_pump_current, loop3_pump_current, loop4_pump_current;
  logic [3:0] loop4_power_of_two_divider, output_common_mode_code;
  logic [7:0] loop2_osc_range, loop3_osc_range, loop4_osc_center;
  logic [7:0] loop4_feedback_low_bits;
  logic [15:0] loop4_divide_ratio;
  logic [6:0] loop4_reference_divider;
  logic [1:0] loop4_feedback_high_bits;
  logic [9:0] loop4_feedback_divider;
  logic [2:0] output_swing_code;
  int errors, checked, cycles;
  // Bank map: offsets, defaults and writable bits
  localparam logic [7:0] ADDRS [12] = '{8'h2F, 8'h30, 8'h31, 8'h32, 8'h33,
    8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A};
  localparam logic [7:0] RSTV [12] = '{8'h02, 8'h0C, 8'h00, 8'h03, 8'h05,
    8'h20, 8'h08, 8'h4B, 8'h02, 8'h00, 8'h16, 8'h49};
  localparam logic [7:0] MASK [12] = '{8'h0F, 8'hFF, 8'h18, 8'h0F, 8'hFF,
    8'hFB, 8'h0F, 8'h7F, 8'h03, 8'hFF, 8'hFF, 8'hFF};

  pllcfg_regs dut_u (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .crosspoint_loop3_on(crosspoint_loop3_on),
    .loop2_pump_current(loop2_pump_current),
    .loop2_osc_range(loop2_osc_range), .loop3_half_rate(loop3_half_rate),
    .loop3_enable(loop3_enable), .loop3_pump_current(loop3_pump_current),
    .loop3_osc_range(loop3_osc_range),
    .loop4_power_of_two_divider(loop4_power_of_two_divider),
    .loop4_divide_ratio(loop4_divide_ratio),
    .loop4_shutdown(loop4_shutdown), .loop4_enable(loop4_enable),
    .ref_high_rate_select(ref_high_rate_select),
    .loop4_ref_source(loop4_ref_source),
    .loop4_pump_current(loop4_pump_current),
    .loop4_reference_divider(loop4_reference_divider),
    .loop4_feedback_high_bits(loop4_feedback_high_bits),
    .loop4_feedback_low_bits(loop4_feedback_low_bits),
    .loop4_feedback_divider(loop4_feedback_divider),
    .loop4_osc_center(loop4_osc_center),
    .output_preemphasis(output_preemphasis),
    .output_swing_code(output_swing_code),
    .output_common_mode_code(output_common_mode_code));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask

  // One access per call; strobe drops at the negedge after it is taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    chk("reg_ack", 16'h0001, {15'h0000, reg_ack});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk("reg_ack", 16'h0001, {15'h0000, reg_ack});
    chk($sformatf("rdata at %h", a), {8'h00, exp}, {8'h00, reg_rdata});
  endtask

  // Write then read back in the very next cycle, with no idle cycle between
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] exp);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    chk("reg_ack", 16'h0001, {15'h0000, reg_ack});
    @(negedge mclk);
    reg_rd = 1'b0;
    chk("reg_ack", 16'h0001, {15'h0000, reg_ack});
    chk($sformatf("rdata at %h", a), {8'h00, exp}, {8'h00, reg_rdata});
  endtask

  task automatic test_reset;
    for (int i = 0; i < 12; i++) rd(ADDRS[i], RSTV[i]);
    chk("loop4_enable", 16'h0001, {15'h0000, loop4_enable});
    chk("fb_div", 16'h0200, {6'h00, loop4_feedback_divider});
    chk("ratio", 16'h0004, loop4_divide_ratio);
    chk("rdiv", 16'h004B, {9'h000, loop4_reference_divider});
    chk("center", 16'h0016, {8'h00, loop4_osc_center});
    chk("range2", 16'h000C, {8'h00, loop2_osc_range});
    chk("range3", 16'h0005, {8'h00, loop3_osc_range});
  endtask

  // Reserved bits must drop out of every readback
  task automatic test_masks;
    for (int i = 0; i < 12; i++) begin
      wr_rd(ADDRS[i], 8'hFF, MASK[i]);
      wr(ADDRS[i], 8'h00);
      rd(ADDRS[i], 8'h00);
    end
  endtask

  task automatic test_loop4;
    wr(8'h34, 8'h5B);
    chk("pow2", 16'h0005, {12'h000, loop4_power_of_two_divider});
    chk("shutdown", 16'h0001, {15'h0000, loop4_shutdown});
    chk("hi_rate", 16'h0001, {15'h0000, ref_high_rate_select});
    chk("ref_src", 16'h0001, {15'h0000, loop4_ref_source});
    wr(8'h37, 8'h01);
    wr(8'h38, 8'hA5);
    @(negedge mclk);
    chk("loop4_enable", 16'h0000, {15'h0000, loop4_enable});
    chk("ratio", 16'h0020, loop4_divide_ratio);
    chk("fb_div", 16'h01A5, {6'h00, loop4_feedback_divider});
    chk("n_high", 16'h0001, {14'h0000, loop4_feedback_high_bits});
    chk("n_low", 16'h00A5, {8'h00, loop4_feedback_low_bits});
    wr(8'h34, 8'hF4);
    @(negedge mclk);
    chk("ratio max", 16'h8000, loop4_divide_ratio);
    chk("loop4_enable", 16'h0001, {15'h0000, loop4_enable});
    chk("ref_src", 16'h0000, {15'h0000, loop4_ref_source});
    wr(8'h35, 8'hFA);
    chk("loop4_pump_current", 16'h000A, {12'h000, loop4_pump_current});
  endtask

  task automatic test_loop3;
    crosspoint_loop3_on = 1'b1;
    wr(8'h31, 8'h10);
    @(negedge mclk);
    chk("half", 16'h0001, {15'h0000, loop3_half_rate});
    chk("loop3_enable", 16'h0001, {15'h0000, loop3_enable});
    wr(8'h31, 8'h08);
    @(negedge mclk);
    chk("loop3 forced", 16'h0000, {15'h0000, loop3_enable});
    wr(8'h31, 8'h00);
    crosspoint_loop3_on = 1'b0;
    @(negedge mclk);
    @(negedge mclk);
    chk("loop3 xpt off", 16'h0000, {15'h0000, loop3_enable});
    wr(8'h32, 8'h07);
    chk("loop3_pump_current", 16'h0007, {12'h000, loop3_pump_current});
    wr(8'h2F, 8'h0C);
    chk("loop2_pump_current", 16'h000C, {12'h000, loop2_pump_current});
  endtask

  task automatic test_driver;
    wr(8'h3A, 8'hF5);
    chk("boost", 16'h0001, {15'h0000, output_preemphasis});
    chk("swing", 16'h0007, {13'h0000, output_swing_code});
    chk("cm", 16'h0005, {12'h000, output_common_mode_code});
    rd(8'h3A, 8'hF5);
  endtask

  // Frozen clock enable takes nothing; unmapped places read zero
  task automatic test_ce_unmapped;
    wr(8'h39, 8'h3C);
    @(negedge mclk);
    ce = 1'b0;
    reg_wr = 1'b1;
    reg_addr = 8'h39;
    reg_wdata = 8'hC3;
    @(negedge mclk);
    @(negedge mclk);
    chk("ack frozen", 16'h0000, {15'h0000, reg_ack});
    reg_wr = 1'b0;
    ce = 1'b1;
    rd(8'h39, 8'h3C);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    rd(8'h39, 8'h3C);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    errors = 0;
    checked = 0;
    cycles = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    crosspoint_loop3_on = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    test_reset();
    test_masks();
    test_loop4();
    test_loop3();
    test_driver();
    test_ce_unmapped();
    end_sim();
  end
endmodule

`default_nettype wire
